//--- hdl/scg_sleep_gate.sv
// Sleep mode clock gating register with enables and fault response
//
// What this block does
// - Bit one clocks unit, zero stops it
// - Access to gated unit gets bus fault
// - Reset clears all gating bits
// - Sleep register acts only during sleep
// - Sleep settings need auto gating select
// - Bit 30 gates the physical layer unit
// - Bit 28 gates the media access unit
// - Register at 0x118, 32 bits, zero reset
// - Unused positions stay inert
// - Bits 6 to 0 gate ports G..A
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module scg_sleep_gate (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [8:0]  run_en_i,
    input  wire logic [8:0]  deep_en_i,
    input  wire logic        acc_valid_i,
    input  wire logic [3:0]  acc_unit_i,
    output logic      [31:0] rdata_o,
    output logic      [8:0]  unit_clk_en_o,
    output logic             bus_fault_o,
    output logic             irq_o
);
    ////////////////////////////////////////////////////////////////////////
    // Register state
    scg_pkg::scg_req_s req;
    scg_pkg::scg_acc_s acc;
    logic [31:0]       sleep_gate_reg_two_q;
    logic [31:0]       run_clock_config_reg_q;
    logic [1:0]        mode_q;
    logic [1:0]        irq_stat_q;
    logic [1:0]        irq_mask_q;
    logic [8:0]        sleep_en;
    logic [8:0]        sel_en;
    logic              fault_d;
    logic              auto_gating_select;
    logic [1:0]        irq_set;

    assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};
    assign acc = '{valid: acc_valid_i, unit: acc_unit_i};
    assign auto_gating_select = run_clock_config_reg_q[scg_pkg::AUTO_GATE_BIT];

    // Address match used by several processes
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sleep gating register, only implemented bits hold state
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sleep_gate_reg_two_q <= scg_pkg::SLEEP_GATE_RST;
        end else if (ce_i && req.wr && hit(req.addr, scg_pkg::SLEEP_GATE_OFF))
        begin
            sleep_gate_reg_two_q <= req.wdata & scg_pkg::SLEEP_GATE_WMASK;
        end
    end

    // Auto gating select bit; other bits of this word are not ours
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            run_clock_config_reg_q <= scg_pkg::ZERO_WORD;
        end else if (ce_i && req.wr && hit(req.addr, scg_pkg::RUN_CFG_OFF))
        begin
            run_clock_config_reg_q <= req.wdata & scg_pkg::RUN_CFG_WMASK;
        end
    end

    // Power mode, driven by software for the sequencer
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mode_q <= scg_pkg::MODE_RST;
        end else if (ce_i && req.wr && hit(req.addr, scg_pkg::MODE_OFF)) begin
            mode_q <= req.wdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unpack gating fields into per-unit enables
    assign sleep_en[8] = sleep_gate_reg_two_q[scg_pkg::PHY_BIT];
    assign sleep_en[7] = sleep_gate_reg_two_q[scg_pkg::MAC_BIT];
    genvar gi;
    generate
        for (gi = 0; gi < scg_pkg::NUM_PORTS; gi++) begin : g_port
            assign sleep_en[gi] = sleep_gate_reg_two_q[scg_pkg::PORT_LSB + gi];
        end
    endgenerate

    // Mode selection of the enable set
    scg_enable_sel u_sel (
        .mode_i      (mode_q),
        .auto_gate_i (auto_gating_select),
        .run_en_i    (run_en_i),
        .sleep_en_i  (sleep_en),
        .deep_en_i   (deep_en_i),
        .en_o        (sel_en)
    );

    // Registered enables: fed to latch-based gates, so no glitches
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            unit_clk_en_o <= scg_pkg::UNITS_ZERO;
        end else if (ce_i) begin
            unit_clk_en_o <= sel_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault detection against the enables in force
    scg_fault_chk u_flt (
        .en_i    (unit_clk_en_o),
        .valid_i (acc.valid),
        .unit_i  (acc.unit),
        .fault_o (fault_d)
    );

    // Fault answer one cycle after the access
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            bus_fault_o <= 1'b0;
        end else if (ce_i) begin
            bus_fault_o <= fault_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status: set wins over write-one-to-clear
    assign irq_set[scg_pkg::IRQ_ACC_FAULT] = fault_d;
    assign irq_set[scg_pkg::IRQ_BUS_FAULT] =
        (req.wr || req.rd) && !hit(req.addr, scg_pkg::SLEEP_GATE_OFF)
        && !hit(req.addr, scg_pkg::RUN_CFG_OFF)
        && !hit(req.addr, scg_pkg::MODE_OFF)
        && !hit(req.addr, scg_pkg::IRQ_STAT_OFF)
        && !hit(req.addr, scg_pkg::IRQ_MASK_OFF);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_stat_q <= scg_pkg::IRQ_ZERO;
        end else if (ce_i) begin
            if (req.wr && hit(req.addr, scg_pkg::IRQ_STAT_OFF)) begin
                irq_stat_q <= (irq_stat_q & ~req.wdata[1:0]) | irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_mask_q <= scg_pkg::IRQ_ZERO;
        end else if (ce_i && req.wr && hit(req.addr, scg_pkg::IRQ_MASK_OFF))
        begin
            irq_mask_q <= req.wdata[1:0];
        end
    end

    // Interrupt level from the next-cycle view of status
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            if (req.wr && hit(req.addr, scg_pkg::IRQ_STAT_OFF)) begin
                irq_o <= |(((irq_stat_q & ~req.wdata[1:0]) | irq_set)
                           & irq_mask_q);
            end else if (req.wr && hit(req.addr, scg_pkg::IRQ_MASK_OFF)) begin
                irq_o <= |((irq_stat_q | irq_set) & req.wdata[1:0]);
            end else begin
                irq_o <= |((irq_stat_q | irq_set) & irq_mask_q);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= scg_pkg::ZERO_WORD;
        end else if (ce_i) begin
            if (!req.rd) begin
                rdata_o <= scg_pkg::ZERO_WORD;
            end else if (hit(req.addr, scg_pkg::SLEEP_GATE_OFF)) begin
                rdata_o <= sleep_gate_reg_two_q;
            end else if (hit(req.addr, scg_pkg::RUN_CFG_OFF)) begin
                rdata_o <= run_clock_config_reg_q;
            end else if (hit(req.addr, scg_pkg::MODE_OFF)) begin
                rdata_o <= {30'h00000000, mode_q};
            end else if (hit(req.addr, scg_pkg::IRQ_STAT_OFF)) begin
                rdata_o <= {30'h00000000, irq_stat_q};
            end else if (hit(req.addr, scg_pkg::IRQ_MASK_OFF)) begin
                rdata_o <= {30'h00000000, irq_mask_q};
            end else begin
                rdata_o <= scg_pkg::ZERO_WORD;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_gate_write;
        ce_i && wr_i && addr_i == scg_pkg::SLEEP_GATE_OFF;
    endsequence

    a_reserved_zero: assert property (@(posedge clk_i)
        (sleep_gate_reg_two_q & ~scg_pkg::SLEEP_GATE_WMASK) == 32'h00000000)
        else $error("reserved gating bit set");

    a_write_lands: assert property (@(posedge clk_i)
        disable iff (srst_i) s_gate_write |=> sleep_gate_reg_two_q ==
        ($past(wdata_i) & scg_pkg::SLEEP_GATE_WMASK))
        else $error("gating write not stored");

    a_reset_clear: assert property (@(posedge clk_i)
        srst_i |=> sleep_gate_reg_two_q == 32'h00000000
        && unit_clk_en_o == 9'h000)
        else $error("reset did not clear");

    a_sleep_apply: assert property (@(posedge clk_i)
        disable iff (srst_i) ce_i && mode_q == 2'b01 && auto_gating_select
        |=> unit_clk_en_o[6:0] == $past(sleep_gate_reg_two_q[6:0]))
        else $error("sleep enables not applied");

    a_auto_needed: assert property (@(posedge clk_i)
        disable iff (srst_i) !srst_i && ce_i && !auto_gating_select
        |=> unit_clk_en_o == $past(run_en_i))
        else $error("sleep set used without auto select");

    a_phy_bit: assert property (@(posedge clk_i)
        disable iff (srst_i) ce_i && mode_q == 2'b01 && auto_gating_select
        |=> unit_clk_en_o[8] == $past(sleep_gate_reg_two_q[30]))
        else $error("phy enable mismatch");

    a_mac_bit: assert property (@(posedge clk_i)
        disable iff (srst_i) ce_i && mode_q == 2'b01 && auto_gating_select
        |=> unit_clk_en_o[7] == $past(sleep_gate_reg_two_q[28]))
        else $error("mac enable mismatch");

    a_gated_fault: assert property (@(posedge clk_i)
        disable iff (srst_i) ce_i && acc_valid_i && acc_unit_i < 4'h9
        && !unit_clk_en_o[acc_unit_i] |=> bus_fault_o)
        else $error("gated access without fault");

    a_clocked_ok: assert property (@(posedge clk_i)
        disable iff (srst_i) ce_i && acc_valid_i && acc_unit_i < 4'h9
        && unit_clk_en_o[acc_unit_i] |=> !bus_fault_o)
        else $error("clocked unit faulted");

    // Reads of the gating register see the stored image
    sequence s_gate_read;
        !srst_i && ce_i && rd_i && addr_i == scg_pkg::SLEEP_GATE_OFF;
    endsequence

    a_read_image: assert property (@(posedge clk_i)
        disable iff (srst_i) s_gate_read
        |=> rdata_o == $past(sleep_gate_reg_two_q))
        else $error("gating register read back wrong");

    a_reserved_read: assert property (@(posedge clk_i)
        disable iff (srst_i) s_gate_read
        |=> (rdata_o & ~scg_pkg::SLEEP_GATE_WMASK) == 32'h00000000)
        else $error("reserved bits read back set");

    // Run mode ignores the sleep set even with auto gating on
    a_run_mode: assert property (@(posedge clk_i)
        disable iff (srst_i) !srst_i && ce_i && mode_q == 2'b00
        |=> unit_clk_en_o == $past(run_en_i))
        else $error("run set not applied in run mode");

    a_deep_mode: assert property (@(posedge clk_i)
        disable iff (srst_i) !srst_i && ce_i && mode_q == 2'b10
        && auto_gating_select |=> unit_clk_en_o == $past(deep_en_i))
        else $error("deep set not applied in deep sleep");

    // Faults come only from an access in the cycle before
    a_fault_cause: assert property (@(posedge clk_i)
        disable iff (srst_i) !srst_i && ce_i && !acc_valid_i
        |=> !bus_fault_o)
        else $error("fault without access");

    // A fault in the same cycle as its clear stays recorded
    a_set_wins: assert property (@(posedge clk_i)
        disable iff (srst_i) !srst_i && ce_i && fault_d
        |=> irq_stat_q[scg_pkg::IRQ_ACC_FAULT])
        else $error("gated access fault not recorded");

    // Interrupt level follows unmasked status with no lag
    a_irq_level: assert property (@(posedge clk_i)
        disable iff (srst_i) irq_o == |(irq_stat_q & irq_mask_q))
        else $error("interrupt level disagrees with status");

    // A low clock enable freezes every register of the block
    a_freeze_hold: assert property (@(posedge clk_i)
        disable iff (srst_i) !srst_i && !ce_i
        |=> $stable(sleep_gate_reg_two_q) && $stable(unit_clk_en_o)
        && $stable(irq_stat_q) && $stable(rdata_o))
        else $error("state moved while clock enable low");
endmodule

//--- hdl/scg_pkg.sv
// Package with offsets, field layout and types of the sleep gating block
package scg_pkg;
    localparam logic [11:0] SLEEP_GATE_OFF   = 12'h118; // Sleep gating register
    localparam logic [11:0] RUN_CFG_OFF      = 12'h060; // Auto gating select holder
    localparam logic [11:0] MODE_OFF         = 12'h1f0; // Power mode control
    localparam logic [11:0] IRQ_STAT_OFF     = 12'h1f4; // Sticky fault status
    localparam logic [11:0] IRQ_MASK_OFF     = 12'h1f8; // Fault interrupt mask
    localparam logic [31:0] SLEEP_GATE_RST   = 32'h00000000;
    localparam logic [31:0] SLEEP_GATE_WMASK = 32'h5000007f;
    localparam int          PHY_BIT          = 30;
    localparam int          MAC_BIT          = 28;
    localparam int          PORT_LSB         = 0;
    localparam int          NUM_PORTS        = 7;
    localparam int          NUM_UNITS        = 9;
    localparam int          AUTO_GATE_BIT    = 27;
    localparam logic [31:0] RUN_CFG_WMASK    = 32'h08000000;
    localparam logic [1:0]  MODE_RST         = 2'h0;
    localparam logic [31:0] ZERO_WORD        = 32'h00000000;
    localparam logic [8:0]  UNITS_ZERO       = 9'h000;
    localparam logic [1:0]  IRQ_ZERO         = 2'h0;
    localparam int          IRQ_ACC_FAULT    = 0;
    localparam int          IRQ_BUS_FAULT    = 1;

    // Power modes seen by the gating select
    typedef enum logic [1:0] {
        MODE_RUN   = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_DEEP  = 2'b10
    } scg_mode_e;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } scg_req_s;

    // Access towards a gated peripheral
    typedef struct packed {
        logic       valid;
        logic [3:0] unit;
    } scg_acc_s;
endpackage

//--- hdl/scg_enable_sel.sv
// Chooses the active enable set from power mode and auto gating select
`timescale 1ns/10ps
module scg_enable_sel (
    input  wire logic [1:0] mode_i,
    input  wire logic       auto_gate_i,
    input  wire logic [8:0] run_en_i,
    input  wire logic [8:0] sleep_en_i,
    input  wire logic [8:0] deep_en_i,
    output logic      [8:0] en_o
);
    // Sleep set only acts in sleep with auto gating selected
    always_comb begin
        case (scg_pkg::scg_mode_e'(mode_i))
            scg_pkg::MODE_SLEEP: en_o = auto_gate_i ? sleep_en_i : run_en_i;
            scg_pkg::MODE_DEEP:  en_o = auto_gate_i ? deep_en_i : run_en_i;
            default:             en_o = run_en_i;
        endcase
    end
endmodule

//--- hdl/scg_fault_chk.sv
// Flags a peripheral access that targets an unclocked unit
`timescale 1ns/10ps
module scg_fault_chk (
    input  wire logic [8:0] en_i,
    input  wire logic       valid_i,
    input  wire logic [3:0] unit_i,
    output logic            fault_o
);
    // Unknown unit numbers count as unclocked
    always_comb begin
        if (valid_i && unit_i < 4'(scg_pkg::NUM_UNITS)) begin
            fault_o = ~en_i[unit_i];
        end else begin
            fault_o = valid_i;
        end
    end
endmodule

//--- verif/scg_periph_model.sv
// Peripheral fabric model that issues accesses towards gated units
`timescale 1ns/10ps
module scg_periph_model (
    input  wire logic       clk_i,
    output logic            acc_valid_o,
    output logic      [3:0] acc_unit_o
);
    // Idle unit lines show a changing value so stale data is never trusted
    initial begin
        acc_valid_o = 1'b0;
        acc_unit_o  = 4'hf;
    end

    ////////////////////////////////////////////////////////////////////////
    // One-cycle access; the fabric never waits for the block
    task automatic access(input logic [3:0] unit);
        @(posedge clk_i);
        acc_valid_o <= 1'b1;
        acc_unit_o  <= unit;
        @(posedge clk_i);
        acc_valid_o <= 1'b0;
        acc_unit_o  <= ~unit;
    endtask
endmodule

//--- verif/testbench.sv
// Self-checking testbench for the sleep clock gating block
`timescale 1ns/10ps
module testbench;
    logic        clk_i;
    logic        srst_i;
    logic        ce_i;
    logic [11:0] addr_i;
    logic [31:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [8:0]  run_en_i;
    logic [8:0]  deep_en_i;
    logic        acc_valid;
    logic [3:0]  acc_unit;
    logic [31:0] rdata_o;
    logic [8:0]  unit_clk_en_o;
    logic        bus_fault_o;
    logic        irq_o;
    int          fail_count;
    int          num_checks;

    scg_sleep_gate scg_sleep_gate_inst (
        .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .run_en_i(run_en_i),
        .deep_en_i(deep_en_i), .acc_valid_i(acc_valid),
        .acc_unit_i(acc_unit), .rdata_o(rdata_o),
        .unit_clk_en_o(unit_clk_en_o), .bus_fault_o(bus_fault_o),
        .irq_o(irq_o));
    scg_periph_model scg_periph_model_inst (
        .clk_i(clk_i), .acc_valid_o(acc_valid), .acc_unit_o(acc_unit));

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Settle n edges, then look 1 ns after the last one
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask

    task automatic fault(input logic [3:0] u, input logic exp);
        scg_periph_model_inst.access(u);
        #1;
        check({31'h0, bus_fault_o}, {31'h0, exp});
    endtask

    // Expected enable set from the sleep register image
    function automatic logic [8:0] gmap(input logic [31:0] r);
        return {r[scg_pkg::PHY_BIT], r[scg_pkg::MAC_BIT], r[6:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_fields();
        rd(scg_pkg::SLEEP_GATE_OFF, 32'h00000000);
        wr(scg_pkg::SLEEP_GATE_OFF, 32'hffffffff);
        rd(scg_pkg::SLEEP_GATE_OFF, 32'h5000007f);
        wr(scg_pkg::SLEEP_GATE_OFF, 32'h00000000);
        rd(scg_pkg::SLEEP_GATE_OFF, 32'h00000000);
    endtask

    task automatic t_modes();
        step(1);
        check({23'h0, unit_clk_en_o}, {23'h0, run_en_i});
        wr(scg_pkg::SLEEP_GATE_OFF, 32'h40000055);
        wr(scg_pkg::MODE_OFF, {30'h0, scg_pkg::MODE_SLEEP});
        step(2);
        check({23'h0, unit_clk_en_o}, {23'h0, run_en_i});
        wr(scg_pkg::RUN_CFG_OFF, 32'h08000000);
        step(2);
        check({23'h0, unit_clk_en_o}, {23'h0, gmap(32'h40000055)});
        wr(scg_pkg::MODE_OFF, {30'h0, scg_pkg::MODE_DEEP});
        step(2);
        check({23'h0, unit_clk_en_o}, {23'h0, deep_en_i});
        wr(scg_pkg::MODE_OFF, {30'h0, scg_pkg::MODE_SLEEP});
        step(2);
    endtask

    // Write lands in the register first, the enable one edge later
    task automatic t_timing();
        wr(scg_pkg::SLEEP_GATE_OFF, 32'h10000003);
        #1;
        check({23'h0, unit_clk_en_o}, {23'h0, gmap(32'h40000055)});
        step(1);
        check({23'h0, unit_clk_en_o}, {23'h0, gmap(32'h10000003)});
    endtask

    task automatic t_fault();
        fault(4'h2, 1'b1);
        fault(4'h0, 1'b0);
        fault(4'h7, 1'b0);
        fault(4'h8, 1'b1);
        fault(4'h9, 1'b1);
        check({31'h0, irq_o}, 32'h0);
        rd(scg_pkg::IRQ_STAT_OFF, 32'h00000001);
        wr(scg_pkg::IRQ_MASK_OFF, 32'h00000003);
        step(2);
        check({31'h0, irq_o}, 32'h1);
        wr(scg_pkg::IRQ_STAT_OFF, 32'h00000001);
        step(2);
        check({31'h0, irq_o}, 32'h0);
        rd(12'h100, 32'h00000000);
        rd(scg_pkg::IRQ_STAT_OFF, 32'h00000002);
        check({31'h0, irq_o}, 32'h1);
        // Fault and its clear in one cycle: the fault must stay
        fork
            wr(scg_pkg::IRQ_STAT_OFF, 32'h00000003);
            scg_periph_model_inst.access(4'h3);
        join
        rd(scg_pkg::IRQ_STAT_OFF, 32'h00000001);
    endtask

    // Low clock enable ignores a write strobe
    task automatic t_freeze();
        @(posedge clk_i);
        ce_i <= 1'b0;
        wr(scg_pkg::SLEEP_GATE_OFF, 32'h00000001);
        @(posedge clk_i);
        ce_i <= 1'b1;
        rd(scg_pkg::SLEEP_GATE_OFF, 32'h10000003);
    endtask

    // Reset in mid-run drops every gating bit and enable
    task automatic t_reset();
        wr(scg_pkg::SLEEP_GATE_OFF, 32'h5000007f);
        srst_i <= 1'b1;
        step(2);
        check({23'h0, unit_clk_en_o}, 32'h00000000);
        @(posedge clk_i);
        srst_i <= 1'b0;
        rd(scg_pkg::SLEEP_GATE_OFF, 32'h00000000);
        step(1);
        check({23'h0, unit_clk_en_o}, {23'h0, run_en_i});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and main sequence
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    initial begin
        #200000;
        fail_count++;
        $display("mismatch at %0t: run timed out", $time);
        stop_test();
    end

    initial begin
        fail_count = 0;
        num_checks = 0;
        srst_i = 1'b1;
        ce_i = 1'b1;
        addr_i = 12'h000;
        wdata_i = 32'h00000000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        run_en_i = 9'h0a5;
        deep_en_i = 9'h13c;
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        // Software must enable every needed unit itself
        t_fields();
        t_modes();
        t_timing();
        t_freeze();
        t_fault();
        t_reset();
        stop_test();
    end
endmodule
